/* File: sltp_map.vh */
// Constants for the serial link test and alignment parameter block.
// Assumes it is included by bare name into the PRBS and top design files of the block; the FIFO does not use it.
`ifndef SLTP_MAP_VH
`define SLTP_MAP_VH

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define SLTP_ADDR_W 12
`define SLTP_OFS_TEST_SEL 12'h205
`define SLTP_OFS_DEV_ID 12'h206
`define SLTP_OFS_EOF_SEL 12'h207
`define SLTP_OFS_STATUS 12'h208
`define SLTP_RST_TEST_SEL 5'h00
`define SLTP_RST_DEV_ID 7'h00
`define SLTP_RST_EOF_SEL 2'h0

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define SLTP_ST_LINK_UP 6
`define SLTP_ST_SYNC 5
`define SLTP_ST_REALIGNED 4
`define SLTP_ST_ALIGNED 3
`define SLTP_ST_PLL_LOCKED 2

// ----------------------------------------------------------------------
// Test selector codes
// ----------------------------------------------------------------------
`define SLTP_T_NORMAL 5'h00
`define SLTP_T_PRBS7 5'h01
`define SLTP_T_PRBS15 5'h02
`define SLTP_T_PRBS23 5'h03
`define SLTP_T_RAMP 5'h04
`define SLTP_T_TRANSPORT 5'h05
`define SLTP_T_D21_5 5'h06
`define SLTP_T_K28_5 5'h07
`define SLTP_T_ILA 5'h08
`define SLTP_T_RPAT 5'h09
`define SLTP_T_LOW 5'h0A
`define SLTP_T_HIGH 5'h0B
`define SLTP_T_PRBS9 5'h0D
`define SLTP_T_PRBS31 5'h0E
`define SLTP_T_CLOCK 5'h0F
`define SLTP_T_K28_7 5'h10

// ----------------------------------------------------------------------
// PRBS polynomial codes and seed
// ----------------------------------------------------------------------
`define SLTP_P_7 3'h0
`define SLTP_P_9 3'h1
`define SLTP_P_15 3'h2
`define SLTP_P_23 3'h3
`define SLTP_P_31 3'h4
`define SLTP_PRBS_SEED 31'h7FFFFFFF

// ----------------------------------------------------------------------
// Line characters and fixed words
// ----------------------------------------------------------------------
`define SLTP_K28_0 8'h1C
`define SLTP_K28_1 8'h3C
`define SLTP_K28_3 8'h7C
`define SLTP_K28_4 8'h9C
`define SLTP_K28_5 8'hBC
`define SLTP_K28_7 8'hFC
`define SLTP_D21_5 8'hB5
`define SLTP_CLOCK_WORD 16'h00FF
`define SLTP_EOF_K28_7 2'h0
`define SLTP_EOF_K28_1 2'h1
`define SLTP_EOF_K28_5 2'h2
`define SLTP_RPAT_LEN 4'h6
`define SLTP_FIFO_DEPTH 32
`define SLTP_LANES 4

`endif

/* File: sltp_fifo.v */
// Sample FIFO with registered read data between sample source and lanes.
// Assumes one clock; the drain side may stall through out_ready.
`timescale 1ns/1ns
`default_nettype none
module sltp_fifo #(
  parameter W = 64,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clock,
  input wire arst_n,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output reg in_ready_q,
  output reg [W-1:0] out_data_q,
  output reg out_valid_q,
  input wire out_ready
);
  localparam integer DEPTH_I = DEPTH;
  localparam [AW:0] DEPTH_C = DEPTH_I[AW:0];

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire load;
  wire [AW:0] cnt_d;

  // A word moves to the output register when it is empty or being taken.
  assign push = in_valid & in_ready_q;
  assign load = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // The array holds no reset so it maps onto plain memory.
  always @(posedge clock) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  // ----------------------------------------------------------------------
  // Pointers, count and output stage
  // ----------------------------------------------------------------------
  // Ready is registered from the next count so a full FIFO refuses at once.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready_q <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q <= {W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != DEPTH_C);
      if (push) begin
        wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (load) begin
        rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
        out_data_q <= mem[rp_q];
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sltp_prbs.v */
// Per-lane pseudo-random generator producing W bits on each advance or restart.
// Assumes restart is held while the link is disabled.
`timescale 1ns/1ns
`default_nettype none
`include "sltp_map.vh"
module sltp_prbs #(
  parameter LANE = 0,
  parameter W = 16
) (
  input wire clock,
  input wire arst_n,
  input wire restart,
  input wire advance,
  input wire [2:0] poly,
  output reg [W-1:0] bits_q
);
  localparam integer LANE_I = LANE + 1;
  localparam [30:0] LANE_MIX = LANE_I[30:0];
  localparam [30:0] SEED = `SLTP_PRBS_SEED ^ LANE_MIX;

  reg [30:0] state_q;
  reg [30:0] s_d;
  reg [W-1:0] b_d;
  integer i;

  // Feedback bit of the selected polynomial.
  function tap;
    input [30:0] s;
    input [2:0] p;
    begin
      case (p)
        `SLTP_P_7: tap = s[6] ^ s[5];
        `SLTP_P_9: tap = s[8] ^ s[4];
        `SLTP_P_15: tap = s[14] ^ s[13];
        `SLTP_P_23: tap = s[22] ^ s[17];
        default: tap = s[30] ^ s[27];
      endcase
    end
  endfunction

  // Step the register W times, oldest bit to the top of the word.
  // During restart the step starts from the seed itself.
  always @* begin
    s_d = restart ? SEED : state_q;
    b_d = {W{1'b0}};
    for (i = 0; i < W; i = i + 1) begin
      b_d[W-1-i] = tap(s_d, poly);
      s_d = {s_d[29:0], b_d[W-1-i]};
    end
  end

  // Each lane starts from its own seed, but the first PRBS31 word is zero on all lanes, PRBS23's on lanes 0-2.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SEED;
      bits_q <= {W{1'b0}};
    end else if (restart) begin
      // Preload the first word so the reset zero in bits_q does not lead the sequence.
      state_q <= s_d;
      bits_q <= b_d;
    end else if (advance) begin
      state_q <= s_d;
      bits_q <= b_d;
    end
  end
endmodule
`default_nettype wire

/* File: sltp_top.v */
// Transmit-side test pattern, alignment identifier and frame-end logic.
// Assumes register accesses come from the device's register bank port,
// and the serializer takes one 16-bit word per lane when tx_ready is high.
//
// What this block does
// - Selector zero sends normal sample data; zero after reset.
// - Selector 1, 2, 3 send PRBS7, PRBS15, PRBS23.
// - Selector 13 and 14 send PRBS9 and PRBS31.
// - Selector 4 sends a ramp; 5 sends the transport-layer pattern.
// - Selector 6 sends repeated D21.5; 7 sends repeated K28.5.
// - Selector 8 repeats the alignment sequence; 9 sends modified RPAT.
// - Selector 10 holds lanes low; 11 holds them high.
// - Selector 15 sends the 0x00FF clock-like word on every lane.
// - Selector 16 sends repeated K28.7; 12 and 17-31 are reserved.
// - Character modes work only in 8b/10b link modes.
// - The identifier goes into the second multiframe of alignment.
// - First link carries the identifier, second link the identifier plus one.
// - Identifier bit zero is ignored and reads back zero.
// - Frame-end select: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// - Frame-end comma is substituted opportunistically, only in 8b/10b.
`timescale 1ns/1ns
`default_nettype none
`include "sltp_map.vh"
module sltp_top #(
  parameter LANES = `SLTP_LANES,
  parameter FIFO_DEPTH = `SLTP_FIFO_DEPTH
) (
  input wire clock,
  input wire arst_n,
  input wire [`SLTP_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  input wire link_enable_control,
  input wire link_mode_8b10b,
  input wire link_up,
  input wire sync_deasserted,
  input wire pll_locked,
  input wire sysref_aligned_evt,
  input wire sysref_realigned_evt,
  input wire [LANES*16-1:0] sample_data,
  input wire sample_valid,
  output wire sample_ready,
  input wire frame_end,
  input wire tx_ready,
  output reg [LANES*16-1:0] lane_data_q,
  output reg [LANES*2-1:0] lane_k_q,
  output reg lane_valid_q
);
  localparam W = LANES * 16;

  // ----------------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------------
  reg [4:0] test_sel_q;
  reg [6:0] dev_id_q;
  reg [1:0] eof_sel_q;
  reg aligned_q;
  reg realigned_q;
  wire wr_status;

  assign wr_status = reg_wr & (reg_addr == `SLTP_OFS_STATUS);

  // Writes store settings; the status flags are sticky and clear on a
  // written one, but a new event in the same cycle keeps the flag set.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      test_sel_q <= `SLTP_RST_TEST_SEL;
      dev_id_q <= `SLTP_RST_DEV_ID;
      eof_sel_q <= `SLTP_RST_EOF_SEL;
      aligned_q <= 1'b0;
      realigned_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `SLTP_OFS_TEST_SEL) begin
        test_sel_q <= reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == `SLTP_OFS_DEV_ID) begin
        dev_id_q <= reg_wdata[7:1];
      end
      if (reg_wr && reg_addr == `SLTP_OFS_EOF_SEL) begin
        eof_sel_q <= reg_wdata[1:0];
      end
      aligned_q <= sysref_aligned_evt |
        (aligned_q & ~(wr_status & reg_wdata[`SLTP_ST_ALIGNED]));
      realigned_q <= sysref_realigned_evt |
        (realigned_q & ~(wr_status & reg_wdata[`SLTP_ST_REALIGNED]));
    end
  end

  // Read data is registered; unmapped offsets return zero.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SLTP_OFS_TEST_SEL: reg_rdata_q <= {3'h0, test_sel_q};
        `SLTP_OFS_DEV_ID: reg_rdata_q <= {dev_id_q, 1'b0};
        `SLTP_OFS_EOF_SEL: reg_rdata_q <= {6'h00, eof_sel_q};
        `SLTP_OFS_STATUS: reg_rdata_q <= {1'b0, link_up, sync_deasserted,
          realigned_q, aligned_q, pll_locked, 2'h0};
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  // Character modes need 8b/10b coding; elsewhere they fall back to low.
  function is_char_mode;
    input [4:0] sel;
    begin
      is_char_mode = (sel == `SLTP_T_K28_5) || (sel == `SLTP_T_ILA) ||
        (sel == `SLTP_T_RPAT) || (sel == `SLTP_T_K28_7);
    end
  endfunction

  // Polynomial code for each PRBS selector value.
  function [2:0] poly_of;
    input [4:0] sel;
    begin
      case (sel)
        `SLTP_T_PRBS7: poly_of = `SLTP_P_7;
        `SLTP_T_PRBS9: poly_of = `SLTP_P_9;
        `SLTP_T_PRBS15: poly_of = `SLTP_P_15;
        `SLTP_T_PRBS23: poly_of = `SLTP_P_23;
        default: poly_of = `SLTP_P_31;
      endcase
    end
  endfunction

  // Modified RPAT pair of bytes for each step of its cycle.
  function [15:0] rpat_word;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: rpat_word = 16'hBED7;
        4'h1: rpat_word = 16'h2347;
        4'h2: rpat_word = 16'h6B8F;
        4'h3: rpat_word = 16'hB314;
        4'h4: rpat_word = 16'h5EFB;
        default: rpat_word = 16'h3559;
      endcase
    end
  endfunction

  wire [4:0] mode;
  wire normal;
  wire step;
  wire restart;
  wire char_bad;
  wire [7:0] eof_char;

  assign normal = (test_sel_q == `SLTP_T_NORMAL);
  assign char_bad = is_char_mode(test_sel_q) & ~link_mode_8b10b;
  assign mode = char_bad ? `SLTP_T_LOW : test_sel_q;
  assign step = link_enable_control & tx_ready;
  assign restart = ~link_enable_control;
  assign eof_char = (eof_sel_q == `SLTP_EOF_K28_1) ? `SLTP_K28_1 :
    (eof_sel_q == `SLTP_EOF_K28_5) ? `SLTP_K28_5 : `SLTP_K28_7;

  // ----------------------------------------------------------------------
  // Sample FIFO
  // ----------------------------------------------------------------------
  wire [W-1:0] fifo_data;
  wire fifo_valid;

  sltp_fifo #(.W(W), .DEPTH(FIFO_DEPTH), .AW($clog2(FIFO_DEPTH))) u_fifo (
    .clock(clock),
    .arst_n(arst_n),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready_q(sample_ready),
    .out_data_q(fifo_data),
    .out_valid_q(fifo_valid),
    .out_ready(step & normal)
  );

  // ----------------------------------------------------------------------
  // Pattern counters
  // ----------------------------------------------------------------------
  reg [7:0] ramp_q;
  reg [3:0] rpat_q;
  reg [3:0] ila_q;

  // Counters advance with each word sent and restart while disabled.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ramp_q <= 8'h00;
      rpat_q <= 4'h0;
      ila_q <= 4'h0;
    end else if (restart) begin
      ramp_q <= 8'h00;
      rpat_q <= 4'h0;
      ila_q <= 4'h0;
    end else if (step) begin
      ramp_q <= ramp_q + 8'h02;
      rpat_q <= (rpat_q == `SLTP_RPAT_LEN - 4'h1) ? 4'h0 : rpat_q + 4'h1;
      ila_q <= ila_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Lane word formation
  // ----------------------------------------------------------------------
  wire [W-1:0] word_d;
  wire [LANES*2-1:0] k_d;
  reg [LANES*8-1:0] last_byte_q;

  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1) begin : g_lane
      localparam integer LANE_I = l;
      localparam [7:0] LANE_ID = LANE_I[7:0];
      wire [15:0] prbs_bits;
      wire [15:0] samp;
      wire [7:0] lane_did;
      reg [15:0] w;
      reg [1:0] k;

      assign samp = fifo_data[l*16 +: 16];
      // First half of the lanes is the first link, the rest the second.
      assign lane_did = (l < LANES / 2) ? {dev_id_q, 1'b0} :
        {dev_id_q, 1'b1};

      sltp_prbs #(.LANE(l), .W(16)) u_prbs (
        .clock(clock),
        .arst_n(arst_n),
        .restart(restart),
        .advance(step),
        .poly(poly_of(test_sel_q)),
        .bits_q(prbs_bits)
      );

      // Select the word this lane carries for the active mode.
      always @* begin
        w = 16'h0000;
        k = 2'b00;
        case (mode)
          `SLTP_T_NORMAL: begin
            w = samp;
            // Opportunistic frame-end comma on a repeated last byte.
            if (link_mode_8b10b && frame_end && samp[7:0] ==
                last_byte_q[l*8 +: 8]) begin
              w = {samp[15:8], eof_char};
              k = 2'b01;
            end
          end
          `SLTP_T_PRBS7, `SLTP_T_PRBS15, `SLTP_T_PRBS23: w = prbs_bits;
          `SLTP_T_PRBS9, `SLTP_T_PRBS31: w = prbs_bits;
          `SLTP_T_RAMP: w = {ramp_q, ramp_q + 8'h01};
          `SLTP_T_TRANSPORT: w = {LANE_ID, ramp_q};
          `SLTP_T_D21_5: w = {`SLTP_D21_5, `SLTP_D21_5};
          `SLTP_T_K28_5: begin
            w = {`SLTP_K28_5, `SLTP_K28_5};
            k = 2'b11;
          end
          `SLTP_T_ILA: begin
            // Four multiframes of four words; the second carries the id.
            w = {ramp_q, LANE_ID};
            if (ila_q[1:0] == 2'h0) begin
              w = {`SLTP_K28_0, ramp_q};
              k = 2'b10;
            end else if (ila_q[1:0] == 2'h3) begin
              w = {ramp_q, `SLTP_K28_3};
              k = 2'b01;
            end else if (ila_q[3:2] == 2'h1 && ila_q[1:0] == 2'h1) begin
              w = {`SLTP_K28_4, lane_did};
              k = 2'b10;
            end
          end
          `SLTP_T_RPAT: w = rpat_word(rpat_q);
          `SLTP_T_LOW: w = 16'h0000;
          `SLTP_T_HIGH: w = 16'hFFFF;
          `SLTP_T_CLOCK: w = `SLTP_CLOCK_WORD;
          `SLTP_T_K28_7: begin
            w = {`SLTP_K28_7, `SLTP_K28_7};
            k = 2'b11;
          end
          default: w = 16'h0000;
        endcase
      end

      assign word_d[l*16 +: 16] = w;
      assign k_d[l*2 +: 2] = k;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------------
  // A word is sent per ready cycle; normal mode also needs FIFO data.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lane_data_q <= {W{1'b0}};
      lane_k_q <= {(LANES*2){1'b0}};
      lane_valid_q <= 1'b0;
      last_byte_q <= {(LANES*8){1'b0}};
    end else if (step && (!normal || fifo_valid)) begin
      lane_data_q <= word_d;
      lane_k_q <= k_d;
      lane_valid_q <= 1'b1;
      if (frame_end) begin
        last_byte_q <= fifo_data_low(fifo_data);
      end
    end else begin
      lane_valid_q <= 1'b0;
    end
  end

  // Last sample byte of each lane, remembered for comma substitution.
  function [LANES*8-1:0] fifo_data_low;
    input [W-1:0] d;
    integer j;
    begin
      fifo_data_low = {(LANES*8){1'b0}};
      for (j = 0; j < LANES; j = j + 1) begin
        fifo_data_low[j*8 +: 8] = d[j*16 +: 8];
      end
    end
  endfunction
endmodule
`default_nettype wire

/* File: sltp_top_assertions.sv */
// Checker for the link test block, watching only the top module's ports.
// Assumes one clock and that settings change only while the link is off.
`timescale 1ns/1ns
`default_nettype none
`include "sltp_map.vh"
module sltp_top_chk #(
  parameter LANES = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [`SLTP_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic link_enable_control,
  input wire logic link_mode_8b10b,
  input wire logic tx_ready,
  input wire logic [LANES*16-1:0] lane_data_q,
  input wire logic [LANES*2-1:0] lane_k_q,
  input wire logic lane_valid_q
);
  logic [4:0] sel_q;
  logic [6:0] id_q;
  // Shadow the selector and identifier so word checks know the active mode.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= 5'h00;
      id_q <= 7'h00;
    end else if (reg_wr && reg_addr == `SLTP_OFS_TEST_SEL) begin
      sel_q <= reg_wdata[4:0];
    end else if (reg_wr && reg_addr == `SLTP_OFS_DEV_ID) begin
      id_q <= reg_wdata[7:1];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_take;
    link_enable_control && tx_ready;
  endsequence
  // A word taken in a fixed-pattern mode shows that pattern on every lane.
  property p_word(code, m, w);
    s_take ##0 (sel_q == code && link_mode_8b10b == m) |=> lane_valid_q && lane_data_q == w;
  endproperty
  chk_held_low:
    assert property (p_word(5'h0A, 1'h1, {LANES{16'h0000}})) else $error("lanes not low");
  chk_held_high:
    assert property (p_word(5'h0B, 1'h1, {LANES{16'hFFFF}})) else $error("lanes not high");
  chk_clock_word:
    assert property (p_word(5'h0F, 1'h1, {LANES{16'h00FF}})) else $error("clock word wrong");
  chk_d21_word:
    assert property (p_word(5'h06, 1'h1, {LANES{16'hB5B5}})) else $error("D21.5 word wrong");
  chk_k28_5_word:
    assert property (p_word(5'h07, 1'h1, {LANES{16'hBCBC}})) else $error("K28.5 word wrong");
  chk_k28_7_word:
    assert property (p_word(5'h10, 1'h1, {LANES{16'hFCFC}})) else $error("K28.7 word wrong");
  chk_k_flags:
    assert property (s_take ##0 (sel_q == 5'h07 && link_mode_8b10b) |=> lane_k_q == '1)
      else $error("control flags missing");
  chk_char_blocked:
    assert property (s_take ##0 (!link_mode_8b10b && (sel_q inside {5'h07, 5'h08, 5'h09, 5'h10}))
      |=> lane_data_q == '0) else $error("character mode active in 64b/66b");
  chk_idle_quiet:
    assert property (!(link_enable_control && tx_ready) |=> !lane_valid_q)
      else $error("word sent while idle");
  chk_sel_readback:
    assert property (reg_rd && reg_addr == `SLTP_OFS_TEST_SEL |=>
      reg_rdata_q == {3'h0, $past(sel_q)}) else $error("selector readback wrong");
  chk_id_even:
    assert property (reg_rd && reg_addr == `SLTP_OFS_DEV_ID |=>
      reg_rdata_q == {$past(id_q), 1'h0}) else $error("identifier readback wrong");
endmodule
bind sltp_top sltp_top_chk #(.LANES(LANES)) chk_u (.clock(clock), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .link_enable_control(link_enable_control),
  .link_mode_8b10b(link_mode_8b10b), .tx_ready(tx_ready), .lane_data_q(lane_data_q),
  .lane_k_q(lane_k_q), .lane_valid_q(lane_valid_q));
`default_nettype wire

/* File: sltp_rx_model.sv */
// Receiver model for the lane side: paces tx_ready and records each lane word.
// Assumes lane outputs are registered and sampled on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module sltp_rx_model #(
  parameter LANES = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic stall,
  input wire logic [LANES*16-1:0] lane_data_q,
  input wire logic [LANES*2-1:0] lane_k_q,
  input wire logic lane_valid_q,
  output var logic tx_ready
);
  logic [LANES*16-1:0] data_mem [0:1023];
  logic [LANES*2-1:0] k_mem [0:1023];
  int rx_count = 0;
  initial tx_ready = 1'h0;
  // Ready every cycle, or every other cycle while stalling, changed just after the edge.
  always @(posedge clock) begin
    tx_ready <= #1 arst_n && (!stall || !tx_ready);
  end
  // Store every word that the block marks valid.
  always @(posedge clock) begin
    if (lane_valid_q === 1'h1) begin
      data_mem[rx_count % 1024] <= lane_data_q;
      k_mem[rx_count % 1024] <= lane_k_q;
      rx_count <= rx_count + 1;
    end
  end
endmodule
`default_nettype wire

/* File: test_sltp_top.sv */
// Self-checking bench for the link test block: register tasks and lane word checks.
// Assumes the block's constants header and the receiver model beside it.
`timescale 1ns/1ns
`default_nettype none
`include "sltp_map.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_sltp_top;
  logic clock, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, sample_valid = 1'h0, stall = 1'h0;
  logic link_enable_control = 1'h0, link_mode_8b10b = 1'h1, frame_end = 1'h0;
  logic link_up = 1'h1, sync_deasserted = 1'h1, pll_locked = 1'h1;
  logic sysref_aligned_evt = 1'h0, sysref_realigned_evt = 1'h0;
  logic sample_ready, tx_ready, lane_valid_q;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata_q, lane_k_q, k0;
  logic [63:0] sample_data = 64'h0, lane_data_q, sd;
  logic [63:0] w [0:7];
  logic [7:0] ec [0:4] = '{8'hFC, 8'h3C, 8'hBC, 8'hFC, 8'h11};
  logic [4:0] tc [0:10] = '{5'h06, 5'h07, 5'h0A, 5'h0B, 5'h0F, 5'h10, 5'h0C, 5'h07, 5'h08,
    5'h09, 5'h10};
  logic [15:0] tw [0:10] = '{16'hB5B5, 16'hBCBC, 16'h0000, 16'hFFFF, 16'h00FF, 16'hFCFC,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [4:0] pc [0:4] = '{5'h01, 5'h02, 5'h03, 5'h0D, 5'h0E};
  int n_fail = 0, comparisons = 0, cycles = 0, b, n, i;
  sltp_top #(.LANES(4), .FIFO_DEPTH(32)) dut_u (.clock(clock), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .link_enable_control(link_enable_control),
    .link_mode_8b10b(link_mode_8b10b), .link_up(link_up), .sync_deasserted(sync_deasserted),
    .pll_locked(pll_locked), .sysref_aligned_evt(sysref_aligned_evt),
    .sysref_realigned_evt(sysref_realigned_evt), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .frame_end(frame_end),
    .tx_ready(tx_ready), .lane_data_q(lane_data_q), .lane_k_q(lane_k_q),
    .lane_valid_q(lane_valid_q));
  sltp_rx_model #(.LANES(4)) rx_u (.clock(clock), .arst_n(arst_n), .stall(stall),
    .lane_data_q(lane_data_q), .lane_k_q(lane_k_q), .lane_valid_q(lane_valid_q),
    .tx_ready(tx_ready));
  // Free-running 100 ns clock.
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  // A run that hangs is counted as a mismatch and closed.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  task automatic cyc;
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    cyc;
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'h1;
    cyc;
    reg_rd = 1'h0;
    cyc;
    `CHK(reg_rdata_q, e)
  endtask
  // Offers one word and holds it until the buffer takes it; valid stays up for the caller.
  task automatic push(input logic [7:0] x);
    sample_data = {4{8'h55, x}};
    sample_valid = 1'h1;
    for (int t = 0; t < 50 && sample_ready !== 1'h1; t++) cyc;
    cyc;
  endtask
  // Programs a selector with the link off, runs the link briefly and keeps the first words.
  task automatic run_sel(input logic [4:0] s, input logic m);
    link_enable_control = 1'h0;
    cyc;
    wr(`SLTP_OFS_TEST_SEL, {3'h0, s});
    link_mode_8b10b = m;
    cyc;
    b = rx_u.rx_count;
    link_enable_control = 1'h1;
    repeat (10) cyc;
    link_enable_control = 1'h0;
    repeat (2) cyc;
    for (int j = 0; j < 8; j++) w[j] = rx_u.data_mem[b + j];
    k0 = rx_u.k_mem[b + 2];
  endtask
  task automatic done(input string s);
    $display("test %s finished, mismatches %0d", s, n_fail);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence: registers, buffer, frame-end commas, then every pattern mode.
  initial begin
    repeat (6) @(posedge clock);
    #1;
    arst_n = 1'h1;
    rd(`SLTP_OFS_TEST_SEL, 8'h00);
    rd(`SLTP_OFS_EOF_SEL, 8'h00);
    wr(`SLTP_OFS_DEV_ID, 8'h0B);
    rd(`SLTP_OFS_DEV_ID, 8'h0A);
    wr(`SLTP_OFS_EOF_SEL, 8'h02);
    rd(`SLTP_OFS_EOF_SEL, 8'h02);
    rd(12'h2FF, 8'h00);
    sysref_aligned_evt = 1'h1;
    sysref_realigned_evt = 1'h1;
    cyc;
    sysref_aligned_evt = 1'h0;
    sysref_realigned_evt = 1'h0;
    rd(`SLTP_OFS_STATUS, 8'h7C);
    wr(`SLTP_OFS_STATUS, 8'h18);
    rd(`SLTP_OFS_STATUS, 8'h64);
    done("registers");
    n = 0;
    while (n < 40 && sample_ready === 1'h1) begin
      sample_data = {4{n[7:0], 8'hA0}};
      sample_valid = 1'h1;
      cyc;
      n++;
    end
    sample_valid = 1'h0;
    `CHK(n, `SLTP_FIFO_DEPTH + 1)
    stall = 1'h1;
    b = rx_u.rx_count;
    link_enable_control = 1'h1;
    for (i = 0; i < 300 && rx_u.rx_count - b < 33; i++) cyc;
    link_enable_control = 1'h0;
    stall = 1'h0;
    cyc;
    `CHK(rx_u.rx_count - b, 33)
    for (i = 0; i < 33; i++) `CHK(rx_u.data_mem[b + i], {4{i[7:0], 8'hA0}})
    `CHK(sample_ready, 1'h1)
    done("buffer");
    for (i = 0; i < 5; i++) begin
      wr(`SLTP_OFS_EOF_SEL, (i == 4) ? 8'h00 : i[7:0]);
      link_mode_8b10b = (i < 4);
      push(8'h11);
      push(8'h11);
      push(8'h22);
      sample_valid = 1'h0;
      frame_end = 1'h1;
      b = rx_u.rx_count;
      link_enable_control = 1'h1;
      repeat (6) cyc;
      link_enable_control = 1'h0;
      frame_end = 1'h0;
      cyc;
      `CHK(rx_u.data_mem[b + 1][7:0], ec[i])
      `CHK(rx_u.k_mem[b + 1][0], i < 4)
      `CHK(rx_u.data_mem[b + 2][7:0], 8'h22)
    end
    wr(`SLTP_OFS_EOF_SEL, 8'h00);
    done("frame end");
    for (i = 0; i < 11; i++) begin
      run_sel(tc[i], i < 7);
      `CHK(w[2], {4{tw[i]}})
      if (i == 1) `CHK(k0, 8'hFF)
    end
    for (i = 0; i < 5; i++) begin
      run_sel(pc[i], 1'h1);
      sd = w[0];
      `CHK(w[1][15:0] !== w[1][31:16], 1'h1)
      `CHK(w[0] !== w[1], 1'h1)
      run_sel(pc[i], 1'h1);
      `CHK(w[0], sd)
    end
    run_sel(5'h04, 1'h1);
    `CHK(w[1][15:0] - w[0][15:0], 16'h0202)
    run_sel(5'h05, 1'h1);
    `CHK(w[1][31:16], 16'h0102)
    run_sel(5'h09, 1'h1);
    `CHK(w[0][15:0], 16'hBED7)
    `CHK(w[6], w[0])
    run_sel(5'h08, 1'h1);
    `CHK(w[0][15:8], 8'h1C)
    `CHK(w[5][15:0], 16'h9C0A)
    `CHK(w[5][47:32], 16'h9C0B)
    done("patterns");
    tally_and_finish;
  end
endmodule
`default_nettype wire
